/* File: logic/sfepp_defs.svh */
// command codes, field positions and timing figures for the flash sequencer
// assumes a 40 MHz core clock; long cycle times become top-level parameters
// Function
// - block erase sets the addressed 64K-byte block to ones, only after write enable
// - block erase is code, 3-byte address, then chip select high; any address selects
// - erase rejected unless chip select rises right after last address byte
// - code takes 8 clocks single-line or 2 in four-line mode; upper lines ignored
// - valid erase/program starts timed cycle; busy reads one, then clears with latch
// - block erase never runs on a block covered by the protect bits
// - chip erase is code only, needs write enable, sets whole array to ones
// - chip erase runs only when all four protect bits are zero
// - page program clears bits to zero and needs write enable first
// - over 256 data bytes: only the last 256 are programmed
// - data past page end wraps to the page's first byte
// - up to 256 bytes program from start address; rest of page unchanged
// - page program: code, 3-byte address, at least one byte, ends on byte boundary
// - program never runs on a page inside the protected region
// - four-line program needs write enable and quad enable; address, data on four lines
// - four-line program only offered in single-line command mode
// - power-down is code only, runs only if chip select rises on the boundary
// - after valid power-down, wait the entry delay then enter power-down
// - in power-down every command but release is ignored
// - release command or reset returns power-down to standby
// - otp enter makes read and program target the 4K-bit otp region
// - in otp mode status/security writes refused; locked region takes only reads
// - otp exit command returns to main array access
// - in otp mode main array access is blocked
`ifndef SFEPP_DEFS_SVH
`define SFEPP_DEFS_SVH

`define SFEPP_CMD_BLOCK64_ERASE   8'hd8
`define SFEPP_CMD_CHIP_ERASE_A    8'h60
`define SFEPP_CMD_CHIP_ERASE_B    8'hc7
`define SFEPP_CMD_PAGE_WRITE      8'h02
`define SFEPP_CMD_QUAD_PAGE_WRITE 8'h38
`define SFEPP_CMD_POWER_DOWN      8'hb9
`define SFEPP_CMD_POWER_RELEASE   8'hab
`define SFEPP_CMD_OTP_ENTER       8'hb1
`define SFEPP_CMD_OTP_EXIT        8'hc1
`define SFEPP_CMD_WRITE_ENABLE    8'h06

`define SFEPP_ADDR_BYTES          2'h3
`define SFEPP_PAGE_BYTES          256
`define SFEPP_BLOCKS              256
`define SFEPP_OTP_ADDR_MSB        9

`define SFEPP_CLK_MHZ             40
`define SFEPP_BLOCK_ERASE_US      1000
`define SFEPP_ARRAY_ERASE_US      20000
`define SFEPP_PAGE_WRITE_US       500
`define SFEPP_POWER_DOWN_NS       3000

`endif

/* File: logic/sfepp_pkg.sv */
// types shared by the flash sequencer and its link sampler
// no assumptions beyond the defs header
package sfepp_pkg;

  typedef enum logic [1:0] {
    sfepp_op_block_erase,
    sfepp_op_chip_erase,
    sfepp_op_program
  } sfepp_op_type;

  typedef struct packed {
    logic         sclk_rise;
    logic         cs_rise;
    logic         cs_fall;
    logic [3:0]   sio;
  } sfepp_link_type;

  typedef struct packed {
    logic         valid;
    sfepp_op_type op;
    logic         otp;
    logic [23:0]  addr;
    logic [7:0]   data;
  } sfepp_mem_type;

endpackage

/* File: logic/sfepp_link_sync.sv */
// synchronises chip select, serial clock and the four data lines, finds edges
// assumes the link clock runs well below a quarter of i_clk
`timescale 1ns/1ps
module sfepp_link_sync (
  input  wire logic                    i_clk,
  input  wire logic                    i_rstn,
  input  wire logic                    i_cs_n,
  input  wire logic                    i_sclk,
  input  wire logic [3:0]              i_sio,
  output sfepp_pkg::sfepp_link_type    o_link
);
  import sfepp_pkg::*;

  logic [5:0] meta;
  logic [5:0] sync;
  logic [1:0] last;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      // idle levels: chip select high, serial clock low, so no false edge follows reset
      meta <= 6'h01;
      sync <= 6'h01;
    end else begin
      meta <= {i_sio, i_sclk, i_cs_n};
      sync <= meta;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      last <= 2'h1;
    end else begin
      last <= sync[1:0];
    end
  end

  // data rides the same two stages as the clock, so it is aligned to the edge
  always_comb begin
    o_link.sclk_rise = sync[1] & ~last[1] & ~sync[0];
    o_link.cs_rise   = sync[0] & ~last[0];
    o_link.cs_fall   = ~sync[0] & last[0];
    o_link.sio       = sync[5:2];
  end
endmodule

/* File: logic/sfepp_timer.sv */
// down-counter for the self-timed cycles and the power-down entry delay
// a load while running restarts the count
`timescale 1ns/1ps
module sfepp_timer #(
  parameter int W = 32
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  output logic              o_done,
  output logic              o_running
);
  logic [W-1:0] left;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      left      <= '0;
      o_running <= 1'b0;
      o_done    <= 1'b0;
    end else if (i_load) begin
      left      <= i_count;
      o_running <= 1'b1;
      o_done    <= 1'b0;
    end else if (o_running) begin
      left      <= left - W'(1);
      o_done    <= (left == W'(1));
      o_running <= (left != W'(1));
    end else begin
      o_done <= 1'b0;
    end
  end
endmodule

/* File: logic/sfepp_core.sv */
// command decoder and self-timed sequencer of the serial flash
// assumes the array behind o_mem applies each request at once; status bits are pins
`timescale 1ns/1ps
`include "sfepp_defs.svh"
module sfepp_core #(
  parameter int BLOCK_ERASE_US = `SFEPP_BLOCK_ERASE_US,
  parameter int ARRAY_ERASE_US = `SFEPP_ARRAY_ERASE_US,
  parameter int PAGE_WRITE_US  = `SFEPP_PAGE_WRITE_US
) (
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  input  wire logic              i_cs_n,
  input  wire logic              i_sclk,
  input  wire logic [3:0]        i_sio,
  input  wire logic              i_four_line_command_mode,
  input  wire logic              i_quad_enable_bit,
  input  wire logic [3:0]        i_protect_bits,
  input  wire logic              i_otp_lockdown_bit,
  output logic                   o_busy_flag,
  output logic                   o_write_enable_latch,
  output logic                   o_power_down,
  output logic                   o_otp_mode,
  output logic                   o_reg_write_allowed,
  output sfepp_pkg::sfepp_mem_type o_mem
);
  import sfepp_pkg::*;

  localparam int BE_CYC = BLOCK_ERASE_US * `SFEPP_CLK_MHZ;
  localparam int CE_CYC = ARRAY_ERASE_US * `SFEPP_CLK_MHZ;
  localparam int PP_CYC = PAGE_WRITE_US * `SFEPP_CLK_MHZ;
  localparam int DP_CYC = (`SFEPP_POWER_DOWN_NS * `SFEPP_CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {st_idle, st_cmd, st_addr, st_data, st_done, st_skip} sfepp_frame_type;

  sfepp_link_type  link;
  sfepp_frame_type state;
  logic [7:0]      shift;
  logic [7:0]      next_shift;
  logic [3:0]      bits;
  logic [3:0]      next_bits;
  logic            byte_done;
  logic            wide;
  logic [7:0]      cmd;
  logic [7:0]      next_cmd_state;
  logic [1:0]      nbytes;
  logic [23:0]     addr;
  logic [7:0]      wr_idx;
  logic            has_data;
  logic            quad_frame;
  logic [7:0]      page_data [`SFEPP_PAGE_BYTES];
  logic [`SFEPP_PAGE_BYTES-1:0] page_mask;
  logic            frame_ok;
  logic            start_be;
  logic            start_ce;
  logic            start_pp;
  logic            start_any;
  logic            dp_exec;
  logic            rdp_exec;
  logic            dp_pending;
  logic            timer_load;
  logic [31:0]     timer_count;
  logic            timer_done;
  logic            timer_running;
  logic            streaming;
  logic [8:0]      stream_idx;
  logic            cur_otp;
  sfepp_op_type    cur_op;

  sfepp_link_sync u_sync (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_cs_n (i_cs_n),
    .i_sclk (i_sclk),
    .i_sio  (i_sio),
    .o_link (link)
  );

  sfepp_timer #(.W(32)) u_timer (
    .i_clk     (i_clk),
    .i_rstn    (i_rstn),
    .i_load    (timer_load),
    .i_count   (timer_count),
    .o_done    (timer_done),
    .o_running (timer_running)
  );

  // highest blocks are protected first; size doubles per protect-bit step
  function automatic logic blk_protected(input logic [3:0] bp, input logic [7:0] blk);
    logic [8:0] span;
    span = 9'h1 << (bp - 4'h1);
    if (bp == 4'h0) begin
      return 1'b0;
    end else if (bp >= 4'h9) begin
      return 1'b1;
    end
    return ({1'b0, blk} >= (9'(`SFEPP_BLOCKS) - span));
  endfunction

  // command code uses four lines only in four-line mode; upper lines ignored otherwise
  always_comb begin
    wide = (state == st_cmd) ? i_four_line_command_mode : (i_four_line_command_mode | quad_frame);
    if (wide) begin
      next_shift = {shift[3:0], link.sio};
      next_bits  = bits + 4'h4;
    end else begin
      next_shift = {shift[6:0], link.sio[0]};
      next_bits  = bits + 4'h1;
    end
    byte_done = (next_bits == 4'h8);
  end

  // next state once the command byte is in
  always_comb begin
    next_cmd_state = 8'(st_skip);
    if (o_power_down) begin
      if (next_shift == `SFEPP_CMD_POWER_RELEASE) next_cmd_state = 8'(st_done);
    end else begin
      case (next_shift)
        `SFEPP_CMD_BLOCK64_ERASE,
        `SFEPP_CMD_PAGE_WRITE:      next_cmd_state = 8'(st_addr);
        `SFEPP_CMD_QUAD_PAGE_WRITE: next_cmd_state = i_four_line_command_mode ? 8'(st_skip) : 8'(st_addr);
        `SFEPP_CMD_CHIP_ERASE_A,
        `SFEPP_CMD_CHIP_ERASE_B,
        `SFEPP_CMD_POWER_DOWN,
        `SFEPP_CMD_OTP_ENTER,
        `SFEPP_CMD_OTP_EXIT,
        `SFEPP_CMD_WRITE_ENABLE:    next_cmd_state = 8'(st_done);
        default:                    next_cmd_state = 8'(st_skip);
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state      <= st_idle;
      shift      <= 8'h00;
      bits       <= 4'h0;
      cmd        <= 8'h00;
      nbytes     <= 2'h0;
      addr       <= 24'h000000;
      wr_idx     <= 8'h00;
      has_data   <= 1'b0;
      quad_frame <= 1'b0;
    end else if (link.cs_fall) begin
      state      <= st_cmd;
      bits       <= 4'h0;
      nbytes     <= 2'h0;
      has_data   <= 1'b0;
      quad_frame <= 1'b0;
    end else if (link.cs_rise) begin
      state <= st_idle;
    end else if (link.sclk_rise) begin
      case (state)
        st_cmd, st_addr, st_data: begin
          shift <= next_shift;
          bits  <= byte_done ? 4'h0 : next_bits;
          if (byte_done && state == st_cmd) begin
            cmd        <= next_shift;
            state      <= sfepp_frame_type'(next_cmd_state[2:0]);
            quad_frame <= (next_shift == `SFEPP_CMD_QUAD_PAGE_WRITE);
          end else if (byte_done && state == st_addr) begin
            addr   <= {addr[15:0], next_shift};
            nbytes <= nbytes + 2'h1;
            if (nbytes == `SFEPP_ADDR_BYTES - 2'h1) begin
              state  <= (cmd == `SFEPP_CMD_BLOCK64_ERASE) ? st_done : st_data;
              wr_idx <= next_shift;
            end
          end else if (byte_done && state == st_data) begin
            wr_idx   <= wr_idx + 8'h01;
            has_data <= 1'b1;
          end
        end
        st_done:  state <= st_skip;
        default:  state <= state;
      endcase
    end
  end

  // page buffer: wrapping index keeps only the last 256 bytes of a long burst
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      page_mask <= '0;
    end else if (link.cs_fall && !o_busy_flag) begin
      page_mask <= '0;
    end else if (link.sclk_rise && byte_done && state == st_data && !o_busy_flag) begin
      page_data[wr_idx] <= next_shift;
      page_mask[wr_idx] <= 1'b1;
    end
  end

  // boundary check: chip select must rise with no partial byte pending
  always_comb begin
    frame_ok = link.cs_rise && (bits == 4'h0) &&
               ((state == st_done) || (state == st_data && has_data));
    start_be = frame_ok && state == st_done && cmd == `SFEPP_CMD_BLOCK64_ERASE && o_write_enable_latch &&
               !o_busy_flag && !o_otp_mode && !blk_protected(i_protect_bits, addr[23:16]);
    start_ce = frame_ok && state == st_done &&
               (cmd == `SFEPP_CMD_CHIP_ERASE_A || cmd == `SFEPP_CMD_CHIP_ERASE_B) && o_write_enable_latch &&
               !o_busy_flag && !o_otp_mode && i_protect_bits == 4'h0;
    start_pp = frame_ok && state == st_data && o_write_enable_latch && !o_busy_flag &&
               (!quad_frame || i_quad_enable_bit) &&
               (o_otp_mode ? (!i_otp_lockdown_bit && addr[23:`SFEPP_OTP_ADDR_MSB] == '0)
                           : !blk_protected(i_protect_bits, addr[23:16]));
    start_any = start_be | start_ce | start_pp;
    dp_exec  = frame_ok && state == st_done && cmd == `SFEPP_CMD_POWER_DOWN && !o_busy_flag;
    rdp_exec = frame_ok && state == st_done && cmd == `SFEPP_CMD_POWER_RELEASE;
    timer_load  = start_any | dp_exec;
    timer_count = start_be ? 32'(BE_CYC) : start_ce ? 32'(CE_CYC) : start_pp ? 32'(PP_CYC) : 32'(DP_CYC);
  end

  // busy and the latch end together when the timed cycle finishes
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_busy_flag          <= 1'b0;
      o_write_enable_latch <= 1'b0;
      cur_op               <= sfepp_op_program;
      cur_otp              <= 1'b0;
    end else if (start_any) begin
      o_busy_flag <= 1'b1;
      cur_op      <= start_be ? sfepp_op_block_erase : start_ce ? sfepp_op_chip_erase : sfepp_op_program;
      cur_otp     <= start_pp && o_otp_mode;
    end else if (o_busy_flag && timer_done) begin
      o_busy_flag          <= 1'b0;
      o_write_enable_latch <= 1'b0;
    end else if (frame_ok && state == st_done && cmd == `SFEPP_CMD_WRITE_ENABLE && !o_busy_flag) begin
      o_write_enable_latch <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_power_down <= 1'b0;
      dp_pending   <= 1'b0;
    end else if (rdp_exec) begin
      o_power_down <= 1'b0;
      dp_pending   <= 1'b0;
    end else if (dp_exec) begin
      dp_pending <= 1'b1;
    end else if (dp_pending && timer_done) begin
      dp_pending   <= 1'b0;
      o_power_down <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_otp_mode <= 1'b0;
    end else if (frame_ok && state == st_done && !o_busy_flag && cmd == `SFEPP_CMD_OTP_ENTER) begin
      o_otp_mode <= 1'b1;
    end else if (frame_ok && state == st_done && !o_busy_flag && cmd == `SFEPP_CMD_OTP_EXIT) begin
      o_otp_mode <= 1'b0;
    end
  end

  // status and security register writers elsewhere must honour this level
  assign o_reg_write_allowed = !o_otp_mode;

  // array requests: erase is one request, program streams the marked bytes
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      streaming  <= 1'b0;
      stream_idx <= 9'h000;
      o_mem      <= '0;
    end else begin
      o_mem.valid <= 1'b0;
      if (start_be || start_ce) begin
        o_mem.valid <= 1'b1;
        o_mem.op    <= start_be ? sfepp_op_block_erase : sfepp_op_chip_erase;
        o_mem.otp   <= 1'b0;
        o_mem.addr  <= {addr[23:16], 16'h0000};
        o_mem.data  <= 8'hff;
      end else if (start_pp) begin
        // page base is held here so that a frame arriving while busy cannot move it
        streaming  <= 1'b1;
        stream_idx <= 9'h000;
        o_mem.addr <= {addr[23:8], 8'h00};
      end else if (streaming) begin
        o_mem.valid <= page_mask[stream_idx[7:0]];
        o_mem.op    <= sfepp_op_program;
        o_mem.otp   <= cur_otp;
        o_mem.addr  <= {o_mem.addr[23:8], stream_idx[7:0]};
        o_mem.data  <= page_data[stream_idx[7:0]];
        stream_idx  <= stream_idx + 9'h001;
        streaming   <= (stream_idx != 9'h0ff);
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence start_seq;
    start_any;
  endsequence

  sequence busy_seq;
    o_busy_flag [*4];
  endsequence

  busy_start_a: assert property (start_seq |=> busy_seq)
    else $error("busy did not hold after a start");
  busy_end_a: assert property ($fell(o_busy_flag) |-> !o_write_enable_latch && $past(timer_done))
    else $error("busy ended without clearing the latch");
  latch_needed_a: assert property ($rose(o_busy_flag) |-> $past(o_write_enable_latch))
    else $error("cycle started with latch clear");
  chip_prot_a: assert property (o_mem.valid && o_mem.op == sfepp_op_chip_erase |-> i_protect_bits == 4'h0)
    else $error("chip erase with protect bits set");
  block_prot_a: assert property (o_mem.valid && o_mem.op == sfepp_op_block_erase |->
                                 !blk_protected($past(i_protect_bits), o_mem.addr[23:16]))
    else $error("protected block erased");
  busy_keep_a: assert property (o_busy_flag && !timer_done |=> o_busy_flag && $stable(cur_op))
    else $error("running cycle disturbed");
  pd_ignore_a: assert property (o_power_down && !rdp_exec |=> o_power_down && !$rose(o_busy_flag))
    else $error("command acted in power-down");
  pd_delay_a: assert property (dp_exec |=> !o_power_down [*4])
    else $error("power-down entered before the delay");
  otp_block_a: assert property (o_mem.valid |-> o_mem.otp == (o_otp_mode && o_mem.op == sfepp_op_program))
    else $error("main array reached in otp mode");
  quad_cmd_a: assert property (start_pp && quad_frame |-> i_quad_enable_bit && !i_four_line_command_mode)
    else $error("four-line program without quad enable");
endmodule

/* File: verif/sfepp_host.sv */
// host controller model: frames commands on chip select, serial clock and four data lines
// assumes i_clk is the 40 MHz core clock; one link clock period is 8 core clocks (200 ns)
`timescale 1ns/1ps
module sfepp_host (
  input  wire logic       i_clk,
  output logic            o_cs_n,
  output logic            o_sclk,
  output logic [3:0]      o_sio
);
  logic [7:0] q[$];

  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sio  = 4'ha;
  end

  // data changes as sclk falls and holds across its rising edge: 8 core clocks a bit
  task automatic tick(input logic [3:0] v);
    o_sio <= v;
    repeat (4) @(posedge i_clk);
    o_sclk <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_sclk <= 1'b0;
  endtask

  // bytes from index qf on go as two nibbles; extra adds stray bits past the boundary
  task automatic frame(input int qf, input int extra);
    repeat (16) @(posedge i_clk);
    o_cs_n <= 1'b0;
    foreach (q[i]) begin
      if (i >= qf) begin
        tick(q[i][7:4]);
        tick(q[i][3:0]);
      end else begin
        for (int b = 7; b >= 0; b--) tick({~o_sio[3:1], q[i][b]});
      end
    end
    repeat (extra) tick(~o_sio);
    repeat (4) @(posedge i_clk);
    o_cs_n <= 1'b1;
    // a released line must not keep showing its last value
    o_sio  <= ~o_sio;
  endtask
endmodule

/* File: verif/sfepp_core_test.sv */
// self-checking bench for the flash sequencer core
// assumes the host model frames every command; the cycle timers are shortened by parameter
`timescale 1ns/1ps
`include "sfepp_defs.svh"
module sfepp_core_test;
  import sfepp_pkg::*;
  logic           clk = 1'b0;
  logic           rstn = 1'b0;
  logic           fmode = 1'b0;
  logic           qe = 1'b0;
  logic           lock = 1'b0;
  logic [3:0]     prot = 4'h0;
  logic           cs_n, sclk, busy, write_enable_latch, pd, otp, rwa;
  logic [3:0]     sio;
  sfepp_mem_type  mem, last;
  logic [7:0]     pd_data [256];
  int             error_cnt = 0;
  int             cmp_count = 0;
  int             n_pulse = 0;
  int             cyc = 0;
  int             run_cnt = 0;
  int             last_len = 0;

  sfepp_core #(.BLOCK_ERASE_US(50), .ARRAY_ERASE_US(1), .PAGE_WRITE_US(10)) DUT (
    .i_clk(clk), .i_rstn(rstn), .i_cs_n(cs_n), .i_sclk(sclk), .i_sio(sio),
    .i_four_line_command_mode(fmode), .i_quad_enable_bit(qe), .i_protect_bits(prot),
    .i_otp_lockdown_bit(lock), .o_busy_flag(busy), .o_write_enable_latch(write_enable_latch), .o_power_down(pd),
    .o_otp_mode(otp), .o_reg_write_allowed(rwa), .o_mem(mem));
  sfepp_host host (.i_clk(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_sio(sio));

  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    run_cnt <= (busy === 1'b1) ? run_cnt + 1 : 0;
    if (busy === 1'b1) last_len <= run_cnt + 1;
    if (mem.valid === 1'b1) begin
      n_pulse <= n_pulse + 1;
      last <= mem;
      pd_data[mem.addr[7:0]] <= mem.data;
    end
    if (cyc == 80000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // data byte k is its index, with the second lap marked so that overwrites show
  task automatic send(logic [7:0] c, bit wa, logic [23:0] a, int nd, int qf, int extra);
    host.q = {c};
    if (wa) host.q = {host.q, a[23:16], a[15:8], a[7:0]};
    for (int k = 0; k < nd; k++) host.q.push_back(k[8] ? 8'hc3 ^ k[7:0] : k[7:0]);
    n_pulse = 0;
    host.frame(qf, extra);
    repeat (8) @(posedge clk);
  endtask

  task automatic write_enable_cmd(int qf);
    send(`SFEPP_CMD_WRITE_ENABLE, 0, 0, 0, qf, 0);
  endtask

  task automatic wait_start(bit exp);
    for (int w = 0; w < 20 && busy !== 1'b1; w++) @(posedge clk);
    chk(busy, exp);
  endtask

  task automatic wait_end(int len);
    for (int w = 0; w < 3000 && busy === 1'b1; w++) @(posedge clk);
    @(posedge clk);
    chk(last_len inside {[len - 1:len + 2]}, 1);
    chk(write_enable_latch, 0);
  endtask

  task automatic t_erase;
    send(`SFEPP_CMD_BLOCK64_ERASE, 1, 24'h051234, 0, 99, 0);
    wait_start(0);
    write_enable_cmd(99);
    chk(write_enable_latch, 1);
    send(`SFEPP_CMD_BLOCK64_ERASE, 1, 24'h051234, 0, 99, 1);
    wait_start(0);
    fmode <= 1'b1;
    send(`SFEPP_CMD_BLOCK64_ERASE, 1, 24'h051234, 0, 0, 0);
    wait_start(1);
    chk(n_pulse, 1);
    chk(last.op, sfepp_op_block_erase);
    chk(last.addr, 24'h050000);
    wait_end(2000);
    fmode <= 1'b0;
  endtask

  task automatic t_protect;
    prot <= 4'h1;
    write_enable_cmd(99);
    send(`SFEPP_CMD_BLOCK64_ERASE, 1, 24'hff8000, 0, 99, 0);
    wait_start(0);
    send(`SFEPP_CMD_CHIP_ERASE_A, 0, 0, 0, 99, 0);
    wait_start(0);
    send(`SFEPP_CMD_PAGE_WRITE, 1, 24'hff0000, 1, 99, 0);
    wait_start(0);
    send(`SFEPP_CMD_BLOCK64_ERASE, 1, 24'hfe0000, 0, 99, 0);
    wait_start(1);
    // a second erase while busy must neither restart nor queue
    write_enable_cmd(99);
    send(`SFEPP_CMD_CHIP_ERASE_B, 0, 0, 0, 99, 0);
    chk(n_pulse, 0);
    wait_end(2000);
    prot <= 4'h0;
    write_enable_cmd(99);
    send(`SFEPP_CMD_CHIP_ERASE_B, 0, 0, 0, 99, 0);
    wait_start(1);
    chk(last.op, sfepp_op_chip_erase);
    wait_end(40);
  endtask

  task automatic t_program;
    write_enable_cmd(99);
    send(`SFEPP_CMD_PAGE_WRITE, 1, 24'h0012fe, 0, 99, 0);
    wait_start(0);
    send(`SFEPP_CMD_PAGE_WRITE, 1, 24'h0012fe, 3, 99, 0);
    wait_start(1);
    wait_end(400);
    chk(n_pulse, 3);
    chk(last.op, sfepp_op_program);
    chk({pd_data[8'hfe], pd_data[8'hff], pd_data[8'h00]}, 24'h000102);
  endtask

  task automatic t_quad;
    write_enable_cmd(99);
    send(`SFEPP_CMD_QUAD_PAGE_WRITE, 1, 24'h000000, 1, 1, 0);
    wait_start(0);
    qe <= 1'b1;
    fmode <= 1'b1;
    send(`SFEPP_CMD_QUAD_PAGE_WRITE, 1, 24'h000000, 1, 0, 0);
    wait_start(0);
    fmode <= 1'b0;
    send(`SFEPP_CMD_QUAD_PAGE_WRITE, 1, 24'h000000, 258, 1, 0);
    wait_start(1);
    wait_end(400);
    chk(n_pulse, 256);
    chk({pd_data[0], pd_data[1], pd_data[2], pd_data[255]}, 32'hc3c202ff);
  endtask

  task automatic t_power;
    send(`SFEPP_CMD_POWER_DOWN, 0, 0, 0, 99, 1);
    repeat (150) @(posedge clk);
    chk(pd, 0);
    send(`SFEPP_CMD_POWER_DOWN, 0, 0, 0, 99, 0);
    repeat (96) @(posedge clk);
    chk(pd, 0);
    repeat (24) @(posedge clk);
    chk(pd, 1);
    write_enable_cmd(99);
    chk(write_enable_latch, 0);
    send(`SFEPP_CMD_POWER_RELEASE, 0, 0, 0, 99, 0);
    chk(pd, 0);
    // a reset in mid-run must also leave power-down
    send(`SFEPP_CMD_POWER_DOWN, 0, 0, 0, 99, 0);
    repeat (130) @(posedge clk);
    chk(pd, 1);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk({busy, write_enable_latch, pd, otp, rwa}, 5'b00001);
  endtask

  task automatic t_otp;
    send(`SFEPP_CMD_OTP_ENTER, 0, 0, 0, 99, 0);
    chk({otp, rwa}, 2'b10);
    write_enable_cmd(99);
    send(`SFEPP_CMD_BLOCK64_ERASE, 1, 24'h000000, 0, 99, 0);
    wait_start(0);
    send(`SFEPP_CMD_PAGE_WRITE, 1, 24'h000010, 1, 99, 0);
    wait_start(1);
    wait_end(400);
    chk(n_pulse, 1);
    chk({last.otp, last.addr}, 25'h1000010);
    write_enable_cmd(99);
    lock <= 1'b1;
    send(`SFEPP_CMD_PAGE_WRITE, 1, 24'h000010, 1, 99, 0);
    wait_start(0);
    send(`SFEPP_CMD_OTP_EXIT, 0, 0, 0, 99, 0);
    chk({otp, rwa}, 2'b01);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk({busy, write_enable_latch, pd, otp, rwa}, 5'b00001);
    t_erase();
    t_protect();
    t_program();
    t_quad();
    t_power();
    t_otp();
    finish_test();
  end
endmodule
